/* File: dv/nand_cmd_addr_latch_bench.sv */
// Purpose: Self-checking bench for the host NAND controller
// Assumes: byte-wide device, one clock per strobe phase (PULSE_CYC 1)
// Notes: waits are bounded; a spent bound ends the run
`default_nettype none
module nand_cmd_addr_latch_bench;
	import nch_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reqValid = 1'b0;
	nch_req_s    reqIn = '0;
	logic        reqReady, refusedPulse, colOutOfRange, deviceBusy, transferDone, readyBusyN;
	nch_pins_s   pinsOut;
	logic [7:0]  lastCmd;
	logic [11:0] column;
	logic [5:0]  page;
	logic [9:0]  block;
	logic [15:0] lastData;
	int          nCmd, faults, mismatches = 0, n_checks = 0;
	logic [7:0]  ops [4] = '{8'h00, 8'h90, 8'hFF, 8'h70};
	always #25 clk = ~clk;
	nch_host #(.PULSE_CYC(1), .WORD_WIDE(1'b0)) DUT (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqReady(reqReady), .reqIn(reqIn), .refusedPulse(refusedPulse), .colOutOfRange(colOutOfRange),
		.deviceBusy(deviceBusy), .transferDone(transferDone), .pinsOut(pinsOut), .readyBusyN(readyBusyN));
	nch_dev_model #(.BUSY_CYC(60)) partner (.clk(clk), .pins(pinsOut), .readyBusyN(readyBusyN),
		.lastCmd(lastCmd), .column(column), .page(page), .block(block), .lastData(lastData),
		.nCmd(nCmd), .faults(faults));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic give_verdict();
	begin
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	end
	endtask
	// A spent wait bound is a mismatch and ends the run
	task automatic bound_hit(input int k, input int lim);
	begin
		if (k >= lim)
		begin
			mismatches++;
			give_verdict();
		end
	end
	endtask
	function automatic nch_req_s mk(nch_kind_e k, logic [7:0] o, logic [11:0] c, logic [5:0] p,
		logic [9:0] b, logic [15:0] d, logic t);
		return '{kind: k, opcode: o, twoCycle: t, column: c, page: p, block: b, data: d};
	endfunction
	task automatic push(input nch_req_s r);
		int k;
	begin
		@(posedge clk);
		reqValid <= 1'b1;
		reqIn <= r;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (reqReady !== 1'b1 && k < 500);
		reqValid <= 1'b0;
		if (k >= 500)
		begin
			mismatches++;
			give_verdict();
		end
	end
	endtask
	// Completion or refusal, whichever comes; refusal must match
	task automatic send(input nch_req_s r, input logic expRef);
		int k;
	begin
		push(r);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (transferDone !== 1'b1 && refusedPulse !== 1'b1 && k < 400);
		if (k >= 400)
		begin
			mismatches++;
			give_verdict();
		end
		check(refusedPulse, expRef);
	end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [11:0] c;
		logic [5:0]  p;
		logic [9:0]  bk;
		logic [15:0] d;
		int          n, n0, nd;
		void'($urandom(32'hC623));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (ops[i])
		begin
			send(mk(NCH_REQ_CMD, ops[i], '0, '0, '0, '0, 1'b0), 1'b0);
			check(lastCmd, ops[i]);
		end
		// Boundary columns first, then random ones
		for (int i = 0; i < 10; i++)
		begin
			c = (i == 0) ? NCH_COL_MAX_X8 : (i == 1) ? 12'h840 : (i == 2) ? 12'hFFF : 12'($urandom);
			p = 6'($urandom);
			bk = 10'($urandom);
			d = 16'($urandom);
			send(mk(NCH_REQ_CMD, 8'h80, '0, '0, '0, '0, 1'b0), 1'b0);
			send(mk(NCH_REQ_ADDR, '0, c, p, bk, '0, 1'b0), c > NCH_COL_MAX_X8);
			if (c <= NCH_COL_MAX_X8)
			begin
				check(column, c);
				check(page, p);
				check(block, bk);
				check(colOutOfRange, 1'b0);
			end
			else
				check(colOutOfRange, 1'b1);
			send(mk(NCH_REQ_DATA, '0, '0, '0, '0, d, 1'b0), 1'b0);
			check(lastData[7:0], d[7:0]);
		end
		// Erase row only: column must stay as it was
		c = column;
		send(mk(NCH_REQ_CMD, 8'h60, '0, '0, '0, '0, 1'b0), 1'b0);
		send(mk(NCH_REQ_ADDR, '0, 12'hFFF, 6'h2A, 10'h3C5, '0, 1'b1), 1'b0);
		check(column, c);
		check(page, 6'h2A);
		check(block, 10'h3C5);
		// Back-to-back commands through the buffer
		n0 = nCmd;
		for (int i = 0; i < 3; i++)
			push(mk(NCH_REQ_CMD, 8'h90, '0, '0, '0, '0, 1'b0));
		n = 0;
		while (nCmd != n0 + 3 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		bound_hit(n, 100);
		check(nCmd - n0, 3);
		// Busy: status passes, data waits and fills the buffer
		send(mk(NCH_REQ_CMD, 8'h10, '0, '0, '0, '0, 1'b0), 1'b0);
		n = 0;
		while (deviceBusy !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		bound_hit(n, 20);
		check(deviceBusy, 1'b1);
		send(mk(NCH_REQ_CMD, NCH_OP_STATUS, '0, '0, '0, '0, 1'b0), 1'b0);
		check(lastCmd, 8'h70);
		// A plain command must wait at the head until busy ends
		push(mk(NCH_REQ_CMD, 8'h80, '0, '0, '0, '0, 1'b0));
		n = 0;
		@(posedge clk);
		reqValid <= 1'b1;
		reqIn <= mk(NCH_REQ_DATA, '0, '0, '0, '0, 16'h0000, 1'b0);
		for (int k = 0; k < 12; k++)
		begin
			@(posedge clk);
			if (reqReady === 1'b1)
			begin
				n++;
				reqIn <= mk(NCH_REQ_DATA, '0, '0, '0, '0, 16'(n), 1'b0);
			end
		end
		reqValid <= 1'b0;
		check(reqReady, 1'b0);
		check(n, NCH_FIFO_DEPTH - 1);
		// Count completions: the held command plus every buffered data word
		n0 = 0;
		nd = 0;
		while (nd < n + 1 && n0 < 400)
		begin
			@(posedge clk);
			nd += (transferDone === 1'b1);
			n0++;
		end
		bound_hit(n0, 400);
		check(lastData[7:0], 8'(n - 1));
		check(lastCmd, 8'h80);
		repeat (2) @(posedge clk);
		check(pinsOut.ceN, 1'b1);
		check(faults, 0);
		give_verdict();
	end
endmodule
`default_nettype wire

/* File: dv/nch_dev_model.sv */
// Purpose: Behavioural NAND device watching the host's pins
// Assumes: pins registered on clk; strobe rise seen as old-to-new change
// Notes: ready/busy released reads high, as through the pull-up
`default_nettype none
module nch_dev_model
	import nch_pkg::*;
#(
	parameter int BUSY_CYC  = 60,
	parameter bit WORD_WIDE = 1'b0
)
(
	// Clock and pins
	input  wire logic      clk,
	input  wire nch_pins_s pins,
	// Device view
	output logic           readyBusyN,
	output logic [7:0]     lastCmd,
	output logic [11:0]    column,
	output logic [5:0]     page,
	output logic [9:0]     block,
	output logic [15:0]    lastData,
	output int             nCmd,
	output int             faults
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prevWe  = 1'b1;
	int         busyCnt = 0;
	int         addrIdx = 0;
	logic [7:0] b;
	assign readyBusyN = (busyCnt == 0);
	initial
	begin
		{lastCmd, column, page, block, lastData} = '0;
		nCmd = 0;
		faults = 0;
	end
	// Raised select or no strobe edge: standby, nothing latched
	always @(posedge clk)
	begin
		b = pins.ioOut[7:0];
		if (busyCnt != 0)
			busyCnt <= busyCnt - 1;
		if (!prevWe && pins.weN && !pins.ceN)
		begin
			if ((pins.cle || pins.ale) && (pins.ioOut[15:8] != 8'h00 || pins.ioOeN[7:0] != 8'h00))
				faults <= faults + 1;
			if (pins.cle && !pins.ale)
			begin
				if (busyCnt != 0 && b != NCH_OP_STATUS && b != NCH_OP_RESET)
					faults <= faults + 1;
				lastCmd <= b;
				nCmd <= nCmd + 1;
				addrIdx <= (b == 8'h60) ? 2 : 0;
				if (b == 8'h10 || b == 8'hD0)
					busyCnt <= BUSY_CYC;
			end
			else if (pins.ale && !pins.cle)
			begin
				case (addrIdx)
					0: column[7:0] <= b;
					1: column[11:8] <= b[3:0];
					2: {block[1:0], page} <= b;
					default: block[9:2] <= b;
				endcase
				if (addrIdx == 1 && (WORD_WIDE ? b[7:3] != 5'h00 : b[7:4] != 4'h0))
					faults <= faults + 1;
				addrIdx <= addrIdx + 1;
			end
			else if (!pins.cle && !pins.ale)
			begin
				if (busyCnt != 0)
					faults <= faults + 1;
				lastData <= pins.ioOut;
			end
		end
		prevWe <= pins.weN;
	end
endmodule
`default_nettype wire

/* File: logic/nch_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: read data registered in storage, shown combinationally from head
`default_nettype none
module nch_fifo
	import nch_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstN,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    wrPtr_d;
	logic [AW-1:0]    rdPtr_q;
	logic [AW-1:0]    rdPtr_d;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             push;
	logic             pop;

	always_comb
	begin
		inReady  = (count_q != (AW+1)'(DEPTH));
		outValid = (count_q != '0);
		outData  = mem_q[rdPtr_q];
		push     = inValid && inReady;
		pop      = outValid && outReady;
		wrPtr_d  = push ? ((wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1) : wrPtr_q;
		rdPtr_d  = pop ? ((rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1) : rdPtr_q;
		count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// Storage has no reset; it is only read when a valid entry exists
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!rstN)
		count_q <= (AW+1)'(DEPTH))
		else $error("FIFO count above depth");
endmodule
`default_nettype wire

/* File: logic/nch_host.sv */
// Purpose: Host controller driving a NAND device's command, address and data cycles
// Assumes: pins driven from clk; device ready/busy arrives asynchronous
// Notes: one accepted request from the FIFO becomes one or more write-strobe cycles; a refused address request becomes none
`default_nettype none
module nch_host
	import nch_pkg::*;
#(
	parameter int  PULSE_CYC = NCH_PULSE_CYC,
	parameter bit  WORD_WIDE = 1'b0
)
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// Request stream
	input  wire logic      reqValid,
	output logic           reqReady,
	input  wire nch_req_s  reqIn,
	// Outcome
	output logic           refusedPulse,
	output logic           colOutOfRange,
	output logic           deviceBusy,
	output logic           transferDone,
	// Device pins
	output nch_pins_s      pinsOut,
	input  wire logic      readyBusyN
);
	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic rstMeta_q;
	logic rstN;
	logic rbMeta_q;
	logic rbSync_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_q <= 1'b0;
			rstN      <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN      <= rstMeta_q;
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rbMeta_q <= 1'b1;
			rbSync_q <= 1'b1;
		end
		else
		begin
			rbMeta_q <= readyBusyN;
			rbSync_q <= rbMeta_q;
		end
	end

	// ----------------------------------------
	// Request FIFO
	// ----------------------------------------
	logic     fifoValid;
	logic     fifoReady;
	nch_req_s req;
	logic [NCH_REQ_W-1:0] fifoData;

	nch_fifo #(
		.WIDTH (NCH_REQ_W),
		.DEPTH (NCH_FIFO_DEPTH)
	) uFifo (
		.clk      (clk),
		.rstN     (rstN),
		.inValid  (reqValid),
		.inReady  (reqReady),
		.inData   (reqIn),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoData)
	);

	assign req = nch_req_s'(fifoData);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic colBad(input logic [11:0] col);
		colBad = WORD_WIDE ? (col > NCH_COL_MAX_X16) : (col > NCH_COL_MAX_X8); // RULE_02 RULE_04 RULE_22
	endfunction

	function automatic logic opWhileBusy(input logic [7:0] op);
		opWhileBusy = (op == NCH_OP_STATUS) || (op == NCH_OP_RESET); // RULE_15 RULE_20
	endfunction

	// Low byte of address cycle n; reserved positions forced to zero
	function automatic logic [7:0] addrByte(input nch_req_s r, input logic [1:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (r.twoCycle)
		begin
			b = (idx == 2'h0) ? {r.block[1:0], r.page} : r.block[9:2]; // RULE_19
		end
		else
		begin
			case (idx)
				2'h0:    b = r.column[7:0];
				2'h1:    b = WORD_WIDE ? {5'h00, r.column[10:8]} : {4'h0, r.column[11:8]}; // RULE_03 RULE_05
				2'h2:    b = {r.block[1:0], r.page}; // RULE_07
				default: b = r.block[9:2]; // RULE_07
			endcase
		end
		addrByte = b;
	endfunction

	// ----------------------------------------
	// Cycle engine
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_LOW   = 4'b0100,
		ST_HIGH  = 4'b1000
	} nch_st_e;

	nch_st_e     state_q;
	nch_st_e     state_d;
	logic [1:0]  idx_q;
	logic [1:0]  idx_d;
	logic [7:0]  tmr_q;
	logic [7:0]  tmr_d;
	nch_pins_s   pins_q;
	nch_pins_s   pins_d;
	logic        refused_q;
	logic        refused_d;
	logic        oob_q;
	logic        oob_d;
	logic        done_q;
	logic        done_d;
	logic        busy;
	logic        lastCyc;
	logic        allowed;

	assign busy = !rbSync_q;
	assign lastCyc = (req.kind != NCH_REQ_ADDR) || (idx_q == (req.twoCycle ? 2'h1 : 2'h3)); // RULE_01
	// Only status and reset may start while busy; others wait in the FIFO, except out-of-range column addresses, which are refused
	assign allowed = !busy || ((req.kind == NCH_REQ_CMD) && opWhileBusy(req.opcode)); // RULE_10 RULE_21
	assign fifoReady = (state_q == ST_IDLE && fifoValid && req.kind == NCH_REQ_ADDR && !req.twoCycle
		&& colBad(req.column)) || (state_q == ST_HIGH && tmr_q == 8'h00 && lastCyc);

	always_comb
	begin
		state_d   = state_q;
		idx_d     = idx_q;
		tmr_d     = tmr_q;
		pins_d    = pins_q;
		refused_d = 1'b0;
		oob_d     = oob_q;
		done_d    = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				pins_d.weN   = 1'b1;
				pins_d.cle   = 1'b0;
				pins_d.ale   = 1'b0;
				pins_d.ioOeN = 16'hFFFF;
				// Drop select when idle and not busy; held through busy is harmless
				pins_d.ceN   = !fifoValid && !busy; // RULE_11 RULE_12
				if (fifoValid)
				begin
					if (req.kind == NCH_REQ_ADDR && !req.twoCycle && colBad(req.column))
					begin
						refused_d = 1'b1; // RULE_22
						oob_d     = 1'b1;
					end
					else if (allowed)
					begin
						if (req.kind == NCH_REQ_ADDR)
						begin
							oob_d = 1'b0;
						end
						pins_d.ceN = 1'b0;
						idx_d      = 2'h0;
						tmr_d      = 8'(PULSE_CYC - 1);
						state_d    = ST_SETUP;
					end
				end
			end
			ST_SETUP:
			begin
				pins_d.cle   = (req.kind == NCH_REQ_CMD); // RULE_13 RULE_14
				pins_d.ale   = (req.kind == NCH_REQ_ADDR); // RULE_13 RULE_17
				pins_d.ioOeN = (WORD_WIDE && req.kind != NCH_REQ_ADDR && req.kind != NCH_REQ_CMD) ? 16'h0000 : 16'h0000;
				case (req.kind)
					NCH_REQ_CMD:  pins_d.ioOut = {8'h00, req.opcode}; // RULE_08 RULE_16
					NCH_REQ_ADDR: pins_d.ioOut = {8'h00, addrByte(req, idx_q)}; // RULE_06 RULE_08
					default:      pins_d.ioOut = WORD_WIDE ? req.data : {8'h00, req.data[7:0]}; // RULE_18
				endcase
				pins_d.weN = 1'b0;
				tmr_d      = 8'(PULSE_CYC - 1);
				state_d    = ST_LOW;
			end
			ST_LOW:
			begin
				if (tmr_q == 8'h00)
				begin
					pins_d.weN = 1'b1; // RULE_14 RULE_17 RULE_18
					tmr_d      = 8'(PULSE_CYC - 1);
					state_d    = ST_HIGH;
				end
				else
				begin
					tmr_d = tmr_q - 8'h01;
				end
			end
			ST_HIGH:
			begin
				if (tmr_q != 8'h00)
				begin
					tmr_d = tmr_q - 8'h01;
				end
				else if (!lastCyc)
				begin
					idx_d   = idx_q + 2'h1; // RULE_01
					state_d = ST_SETUP;
				end
				else
				begin
					done_d  = 1'b1; // RULE_09
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_q   <= ST_IDLE;
			idx_q     <= 2'h0;
			tmr_q     <= 8'h00;
			pins_q    <= '{ceN: 1'b1, cle: 1'b0, ale: 1'b0, weN: 1'b1, reN: 1'b1,
				ioOut: 16'h0000, ioOeN: 16'hFFFF};
			refused_q <= 1'b0;
			oob_q     <= 1'b0;
			done_q    <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			idx_q     <= idx_d;
			tmr_q     <= tmr_d;
			pins_q    <= pins_d;
			refused_q <= refused_d;
			oob_q     <= oob_d;
			done_q    <= done_d;
		end
	end

	assign pinsOut       = pins_q;
	assign refusedPulse  = refused_q;
	assign colOutOfRange = oob_q;
	assign transferDone  = done_q;
	assign deviceBusy    = busy;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_latch_excl: assert property (@(posedge clk) disable iff (!rstN)
		!(pins_q.cle && pins_q.ale)) // RULE_13
		else $error("Both latch strobes high");
	a_strobe_sel: assert property (@(posedge clk) disable iff (!rstN)
		$rose(pins_q.weN) |-> !pins_q.ceN) // RULE_10
		else $error("Write strobe edge without select");
	a_cmd_upper: assert property (@(posedge clk) disable iff (!rstN)
		(pins_q.cle || pins_q.ale) && !pins_q.weN |-> pins_q.ioOut[15:8] == 8'h00) // RULE_08
		else $error("Upper byte not zero in command or address");
	a_busy_cmd: assert property (@(posedge clk) disable iff (!rstN)
		state_q == ST_IDLE && fifoValid && busy && req.kind == NCH_REQ_CMD && !opWhileBusy(req.opcode)
		|=> state_q == ST_IDLE) // RULE_21
		else $error("Command started while busy");
	a_status_busy: assert property (@(posedge clk) disable iff (!rstN)
		state_q == ST_IDLE && fifoValid && req.kind == NCH_REQ_CMD && req.opcode == NCH_OP_STATUS
		|=> state_q == ST_SETUP) // RULE_15
		else $error("Status command not started");
	a_col_refuse: assert property (@(posedge clk) disable iff (!rstN)
		state_q == ST_IDLE && fifoValid && req.kind == NCH_REQ_ADDR && !req.twoCycle
		&& colBad(req.column) |=> refused_q && oob_q) // RULE_22
		else $error("Out-of-range column not refused");
	a_x8_second: assert property (@(posedge clk) disable iff (!rstN)
		!WORD_WIDE && state_q == ST_SETUP && req.kind == NCH_REQ_ADDR && !req.twoCycle && idx_q == 2'h1
		|=> pins_q.ioOut[7:4] == 4'h0) // RULE_03
		else $error("Second cycle high nibble not zero");
	a_x16_second: assert property (@(posedge clk) disable iff (!rstN)
		WORD_WIDE && state_q == ST_SETUP && req.kind == NCH_REQ_ADDR && !req.twoCycle && idx_q == 2'h1
		|=> pins_q.ioOut[7:3] == 5'h00) // RULE_05
		else $error("Second cycle upper five lines not zero");
	a_cmd_strobe: assert property (@(posedge clk) disable iff (!rstN)
		$rose(pins_q.weN) && pins_q.cle |-> !pins_q.ale && !pins_q.ceN && $stable(pins_q.ioOut)) // RULE_14
		else $error("Command strobe edge with wrong latch levels or moving data");
endmodule
`default_nettype wire

/* File: logic/nch_pkg.sv */
// Purpose: Constants and types for the host-side NAND command/address controller
// Assumes: 20 MHz clk; device strobes driven from this clock with divided timing
// Notes:
// How it works
// RULE_01 - Host sends every full array address as four byte cycles.
// RULE_02 - Byte-wide column is 12 bits; columns above 2111 are refused.
// RULE_03 - Byte-wide second address cycle drives upper four low-byte lines zero.
// RULE_04 - Word-wide column is 11 bits; columns above 1055 are refused.
// RULE_05 - Word-wide second address cycle drives lines 7:3 zero.
// RULE_06 - Word-wide address cycles drive upper byte lines zero.
// RULE_07 - Cycle three carries page 5:0 and block 7:6; cycle four block 15:8.
// RULE_08 - Commands and addresses use only the low eight lines.
// RULE_09 - Operations go command phase, then address phase, then data phase.
// RULE_10 - Device accepts transfers only with chip select low and not busy.
// RULE_11 - Raising chip select while not busy puts the device in standby.
// RULE_12 - While busy the device ignores chip select; host may release it.
// RULE_13 - Command latch high means command cycle; address latch high means address.
// RULE_14 - Command captured on write rising edge with select low, command latch high.
// RULE_15 - Status-read and reset commands may be sent while busy.
// RULE_16 - Word-wide command cycles drive upper byte lines zero.
// RULE_17 - Address captured on write rising edge with address latch high only.
// RULE_18 - Data captured on write rising edge with both latches low, not busy.
// RULE_19 - Block erase sends only two address cycles carrying the row.
// RULE_20 - Status-read opcode 70h may be polled instead of ready/busy.
// RULE_21 - Commands other than status or reset are withheld while busy.
// RULE_22 - Out-of-range columns are flagged and their operation refused; code refuses only the address request.
`default_nettype none
package nch_pkg;
	localparam logic [7:0]  NCH_OP_STATUS   = 8'h70;
	localparam logic [7:0]  NCH_OP_RESET    = 8'hFF;
	localparam logic [11:0] NCH_COL_MAX_X8  = 12'h83F;
	localparam logic [11:0] NCH_COL_MAX_X16 = 12'h41F;
	localparam int          NCH_CLK_NS      = 50;
	localparam int          NCH_PULSE_NS    = 50;
	localparam int          NCH_PULSE_CYC   = (NCH_PULSE_NS + NCH_CLK_NS - 1) / NCH_CLK_NS;
	localparam int          NCH_FIFO_DEPTH  = 8;

	// Request kinds
	typedef enum logic [1:0] {
		NCH_REQ_CMD  = 2'h0,
		NCH_REQ_ADDR = 2'h1,
		NCH_REQ_DATA = 2'h2
	} nch_kind_e;

	// One host request: command byte, address, or data word
	typedef struct packed {
		nch_kind_e   kind;
		logic [7:0]  opcode;
		logic        twoCycle;
		logic [11:0] column;
		logic [5:0]  page;
		logic [9:0]  block;
		logic [15:0] data;
	} nch_req_s;

	localparam int NCH_REQ_W = $bits(nch_req_s);

	// Pins toward the device
	typedef struct packed {
		logic        ceN;
		logic        cle;
		logic        ale;
		logic        weN;
		logic        reN;
		logic [15:0] ioOut;
		logic [15:0] ioOeN;
	} nch_pins_s;
endpackage
`default_nettype wire
